// *** inc/pvd_defines.svh ***
/*
  Register offsets, field positions, reset values and bus codes for the
  PCI-to-VMEbus image decode block. Included by the top.
*/
`ifndef PVD_DEFINES_SVH
`define PVD_DEFINES_SVH
// ==========================================================
// Register byte offsets
`define PVD_OFF_SPECIAL   12'h018
`define PVD_OFF_CMDLOG    12'h18c
`define PVD_OFF_ADDRERR   12'h190
`define PVD_OFF_IMG4_CTL  12'h1a0
`define PVD_OFF_IMG4_BASE 12'h1a4
`define PVD_OFF_IMG4_BND  12'h1a8
`define PVD_OFF_IMG4_TO   12'h1b0
// ==========================================================
// Writable bit masks and reset values
`define PVD_MASK_SPECIAL  32'hc0f0_fffd
`define PVD_MASK_IMG4_CTL 32'hc0c7_5101
`define PVD_MASK_4K       32'hffff_f000
`define PVD_RST_IMG4_CTL  32'h0080_0000
`define PVD_RST_CMD       4'h7
// ==========================================================
// Field positions
`define PVD_EN        31
`define PVD_POST_EN   30
`define PVD_IO_SPACE  0
`define PVD_SP_WIDTH  23:20
`define PVD_SP_PROG   15:12
`define PVD_SP_SUP    11:8
`define PVD_SP_BASE   7:2
`define PVD_I4_WIDTH  23:22
`define PVD_I4_SPACE  18:16
`define PVD_I4_PROG   14
`define PVD_I4_SUP    12
`define PVD_I4_BLOCK  8
`define PVD_LSTAT     23
// ==========================================================
// Space and width codes
`define PVD_SPACE_A16   3'h0
`define PVD_SPACE_A24   3'h1
`define PVD_SPACE_A32   3'h2
`define PVD_SPACE_CRCSR 3'h5
`define PVD_SPACE_USER1 3'h6
`define PVD_SPACE_USER2 3'h7
`define PVD_W16       2'h1
`define PVD_W32       2'h2
`define PVD_W64       2'h3
`define PVD_AM_CRCSR  6'h2f
`define PVD_AM_USER1  6'h10
`define PVD_AM_USER2  6'h11
`define PVD_A16_TOP   8'hff
`define PVD_RESP_OK   2'h0
`define PVD_RESP_ERR  2'h2
`endif

// *** inc/pvd_pkg.sv ***
/*
  Types for the image decode block: the single state record of the top.
  Assumes nothing beyond the defines header.
*/
package pvd_pkg;
  // ==========================================================
  // State of the top module, apart from the reset release flops
  typedef struct packed {
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] special;
    logic [31:0] ctl4;
    logic [31:0] base4;
    logic [31:0] bnd4;
    logic [31:0] to4;
    logic [3:0]  err_cmd;
    logic        err_multi;
    logic        log_valid;
    logic [31:0] err_addr;
    logic        dec_done;
    logic        hit_sp;
    logic        hit_4;
    logic [31:0] vme_addr;
    logic [5:0]  vme_am;
    logic [1:0]  vme_width;
    logic        posted;
    logic        blt;
    logic        mblt;
  } pvd_state_s;
endpackage

// *** verilog/pvd_image_decode.sv ***
/*
  Slave-path decode for a PCI-to-VMEbus bridge: special 64 Mbyte image,
  general target image 4 and the posted-write error log, with registers
  on AXI4-Lite. Assumes all inputs come from logic on SYS_CLK and that
  DEC_OTHER_HIT reports hits of images outside this block.
*/
`timescale 1ns/1ps
`include "pvd_defines.svh"

// Behaviour
// - Special image is 64 Mbyte aligned; hits when address [31:26] equals base.
// - Any other image hit overrides the special image.
// - Address [25:24] picks one of four 16 Mbyte regions.
// - Top 64 Kbyte of each region goes to A16, rest to A24.
// - Per-region width bit: 0 gives 16-bit, 1 gives 32-bit port.
// - Per-region program/data bit; ignored in the A16 part.
// - Per-region supervisor/user bit, low bits for low regions.
// - Special image only makes single-cycle address modifiers.
// - Each image answers only in its selected PCI memory or I/O space.
// - Writes are posted only when the image's posted bit is 1.
// - I/O space images ignore the posted bit; all coupled.
// - Image 4 width field, 8/16/32/64, resets to 32-bit.
// - Image 4 space field: A16, A24, A32, CR/CSR, User1, User2.
// - Block cycle bit acts only for A24/A32 at 8-32 bit width.
// - A24/A32 at 64-bit width allows MBLT regardless of block bit.
// - Image 4 single program/data and supervisor/user bits.
// - Log on posted write target abort, master abort or retry expiry.
// - Failed command is logged read-only, reset value 0111.
// - Failed start address logged read-only, valid while log valid.
// - Log valid reads 1 when frozen; write 1 clears it, 0 ignored.
// - Multiple-error flag sets on any error while logs are frozen, except in a cycle that writes the clear.
// - Image 4 hits from base up to bound, or unbounded when bound 0.
// - Image 4 base and bound have 4 Kbyte resolution.
// - Image 4 VME address [31:12] is PCI address plus offset.
module pvd_image_decode
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic [2:0]  S_AXI_AWPROT,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic [2:0]  S_AXI_ARPROT,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        DEC_VALID,
  input  wire logic [31:0] DEC_ADDR,
  input  wire logic        DEC_IO,
  input  wire logic        DEC_WRITE,
  input  wire logic        DEC_OTHER_HIT,
  output logic             DEC_DONE,
  output logic             DEC_HIT_SPECIAL,
  output logic             DEC_HIT_IMG4,
  output logic [31:0]      DEC_VME_ADDR,
  output logic [5:0]       DEC_VME_AM,
  output logic [1:0]       DEC_VME_WIDTH,
  output logic             DEC_POSTED,
  output logic             DEC_BLT,
  output logic             DEC_MBLT,
  input  wire logic        ERR_TARGET_ABORT,
  input  wire logic        ERR_MASTER_ABORT,
  input  wire logic        ERR_RETRY_EXPIRED,
  input  wire logic        ERR_POSTED,
  input  wire logic [3:0]  ERR_CMD,
  input  wire logic [31:0] ERR_ADDR,
  output logic             LOG_VALID
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old & ~m) | (nw & m);
  endfunction

  // Single-cycle codes only unless blt or mblt is asked for
  function automatic logic [5:0] am_code(input logic [2:0] space, input logic sup,
                                         input logic prog, input logic blt, input logic mblt);
    logic [1:0] lo;
    lo = mblt ? 2'h0 : (blt ? 2'h3 : (prog ? 2'h2 : 2'h1));
    case (space)
      `PVD_SPACE_A16:   am_code = {3'h5, sup, 2'h1};
      `PVD_SPACE_A24:   am_code = {3'h7, sup, lo};
      `PVD_SPACE_A32:   am_code = {3'h1, sup, lo};
      `PVD_SPACE_CRCSR: am_code = `PVD_AM_CRCSR;
      `PVD_SPACE_USER1: am_code = `PVD_AM_USER1;
      `PVD_SPACE_USER2: am_code = `PVD_AM_USER2;
      default:        am_code = 6'h00;
    endcase
  endfunction

  // ==========================================================
  // Reset release
  logic             rst_meta_n;
  logic             rst_n;
  pvd_pkg::pvd_state_s s_r;
  pvd_pkg::pvd_state_s s_nxt;

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ==========================================================
  // Next state
  logic        wr_go;
  logic        any_err;
  logic        i4_hit;
  logic        sp_hit;
  logic        i4_wide;
  logic        sp_a16;
  logic [1:0]  region;
  logic [2:0]  space4;
  logic [1:0]  width4;
  logic [31:0] rd_val;
  logic        rd_ok;

  always_comb
  begin
    s_nxt = s_r;
    wr_go = 1'b0;
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    space4 = s_r.ctl4[`PVD_I4_SPACE];
    width4 = s_r.ctl4[`PVD_I4_WIDTH];
    region = DEC_ADDR[25:24];
    sp_a16 = DEC_ADDR[23:16] == `PVD_A16_TOP;
    i4_wide = (space4 == `PVD_SPACE_A24) || (space4 == `PVD_SPACE_A32);

    // Write channels may arrive in either order
    if (S_AXI_AWVALID && s_r.awready)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s_r.wready)
    begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = S_AXI_WDATA;
      s_nxt.w_strb = S_AXI_WSTRB;
    end
    if (S_AXI_BVALID && S_AXI_BREADY)
      s_nxt.bvalid = 1'b0;

    // Error capture; a new error beats a same-cycle clear
    any_err = ERR_POSTED && (ERR_TARGET_ABORT || ERR_MASTER_ABORT || ERR_RETRY_EXPIRED);

    if (s_r.aw_held && s_r.w_held && !s_r.bvalid)
    begin
      wr_go = 1'b1;
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `PVD_RESP_OK;
      case ({s_r.aw_addr[11:2], 2'b00})
        `PVD_OFF_SPECIAL:   s_nxt.special = merge(s_r.special, s_r.w_data, s_r.w_strb, `PVD_MASK_SPECIAL);
        `PVD_OFF_IMG4_CTL:  s_nxt.ctl4 = merge(s_r.ctl4, s_r.w_data, s_r.w_strb, `PVD_MASK_IMG4_CTL);
        `PVD_OFF_IMG4_BASE: s_nxt.base4 = merge(s_r.base4, s_r.w_data, s_r.w_strb, `PVD_MASK_4K);
        `PVD_OFF_IMG4_BND:  s_nxt.bnd4 = merge(s_r.bnd4, s_r.w_data, s_r.w_strb, `PVD_MASK_4K);
        `PVD_OFF_IMG4_TO:   s_nxt.to4 = merge(s_r.to4, s_r.w_data, s_r.w_strb, `PVD_MASK_4K);
        `PVD_OFF_CMDLOG:
        begin
          // Only the status bit is writable; zero leaves it alone
          if (s_r.w_strb[2] && s_r.w_data[`PVD_LSTAT])
          begin
            s_nxt.log_valid = 1'b0;
            s_nxt.err_multi = 1'b0;
          end
        end
        `PVD_OFF_ADDRERR: s_nxt.bresp = `PVD_RESP_OK;
        default:          s_nxt.bresp = `PVD_RESP_ERR;
      endcase
    end

    if (any_err)
    begin
      if (!s_nxt.log_valid || !s_r.log_valid)
      begin
        s_nxt.err_cmd = ERR_CMD;
        s_nxt.err_addr = ERR_ADDR;
        s_nxt.log_valid = 1'b1;
        s_nxt.err_multi = 1'b0;
      end
      else
        s_nxt.err_multi = 1'b1;
    end

    s_nxt.awready = !s_nxt.aw_held && !wr_go;
    s_nxt.wready = !s_nxt.w_held && !wr_go;

    // Read path: one outstanding read
    case ({S_AXI_ARADDR[11:2], 2'b00})
      `PVD_OFF_SPECIAL:   rd_val = s_r.special;
      `PVD_OFF_IMG4_CTL:  rd_val = s_r.ctl4;
      `PVD_OFF_IMG4_BASE: rd_val = s_r.base4;
      `PVD_OFF_IMG4_BND:  rd_val = s_r.bnd4;
      `PVD_OFF_IMG4_TO:   rd_val = s_r.to4;
      `PVD_OFF_CMDLOG:    rd_val = {s_r.err_cmd, s_r.err_multi, 3'h0, s_r.log_valid, 23'h0};
      `PVD_OFF_ADDRERR:   rd_val = s_r.err_addr;
      default:            rd_ok = 1'b0;
    endcase
    if (S_AXI_RVALID && S_AXI_RREADY)
      s_nxt.rvalid = 1'b0;
    if (S_AXI_ARVALID && s_r.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_val;
      s_nxt.rresp = rd_ok ? `PVD_RESP_OK : `PVD_RESP_ERR;
    end
    s_nxt.arready = !s_nxt.rvalid;

    // Address decode, answered one cycle after the request
    i4_hit = s_r.ctl4[`PVD_EN] && (s_r.ctl4[`PVD_IO_SPACE] == DEC_IO)
             && (DEC_ADDR[31:12] >= s_r.base4[31:12])
             && ((s_r.bnd4[31:12] == 20'h00000) || (DEC_ADDR[31:12] < s_r.bnd4[31:12]));
    sp_hit = s_r.special[`PVD_EN] && (s_r.special[`PVD_IO_SPACE] == DEC_IO)
             && (DEC_ADDR[31:26] == s_r.special[`PVD_SP_BASE])
             && !i4_hit && !DEC_OTHER_HIT;
    s_nxt.dec_done = DEC_VALID;
    s_nxt.hit_sp = DEC_VALID && sp_hit;
    s_nxt.hit_4 = DEC_VALID && i4_hit;
    s_nxt.blt = 1'b0;
    s_nxt.mblt = 1'b0;
    s_nxt.posted = 1'b0;
    s_nxt.vme_addr = 32'h0000_0000;
    s_nxt.vme_am = 6'h00;
    s_nxt.vme_width = 2'h0;
    if (DEC_VALID && i4_hit)
    begin
      s_nxt.vme_addr = {DEC_ADDR[31:12] + s_r.to4[31:12], DEC_ADDR[11:0]};
      s_nxt.vme_width = width4;
      s_nxt.blt = s_r.ctl4[`PVD_I4_BLOCK] && i4_wide && (width4 != `PVD_W64);
      s_nxt.mblt = i4_wide && (width4 == `PVD_W64);
      s_nxt.vme_am = am_code(space4, s_r.ctl4[`PVD_I4_SUP], s_r.ctl4[`PVD_I4_PROG],
                             s_nxt.blt, s_nxt.mblt);
      // I/O images never post
      s_nxt.posted = DEC_WRITE && !DEC_IO && s_r.ctl4[`PVD_POST_EN];
    end
    else if (DEC_VALID && sp_hit)
    begin
      s_nxt.vme_addr = sp_a16 ? {16'h0000, DEC_ADDR[15:0]} : {8'h00, DEC_ADDR[23:0]};
      s_nxt.vme_width = s_r.special[20 + region] ? `PVD_W32 : `PVD_W16;
      // No block codes from this image
      s_nxt.vme_am = am_code(sp_a16 ? `PVD_SPACE_A16 : `PVD_SPACE_A24,
                             s_r.special[8 + region], s_r.special[12 + region], 1'b0, 1'b0);
      s_nxt.posted = DEC_WRITE && !DEC_IO && s_r.special[`PVD_POST_EN];
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.ctl4 <= `PVD_RST_IMG4_CTL;
      s_r.err_cmd <= `PVD_RST_CMD;
    end
    else
      s_r <= s_nxt;
  end

  assign S_AXI_AWREADY   = s_r.awready;
  assign S_AXI_WREADY    = s_r.wready;
  assign S_AXI_BVALID    = s_r.bvalid;
  assign S_AXI_BRESP     = s_r.bresp;
  assign S_AXI_ARREADY   = s_r.arready;
  assign S_AXI_RVALID    = s_r.rvalid;
  assign S_AXI_RDATA     = s_r.rdata;
  assign S_AXI_RRESP     = s_r.rresp;
  assign DEC_DONE        = s_r.dec_done;
  assign DEC_HIT_SPECIAL = s_r.hit_sp;
  assign DEC_HIT_IMG4    = s_r.hit_4;
  assign DEC_VME_ADDR    = s_r.vme_addr;
  assign DEC_VME_AM      = s_r.vme_am;
  assign DEC_VME_WIDTH   = s_r.vme_width;
  assign DEC_POSTED      = s_r.posted;
  assign DEC_BLT         = s_r.blt;
  assign DEC_MBLT        = s_r.mblt;
  assign LOG_VALID       = s_r.log_valid;

endmodule

// *** verif/pvd_image_decode_chk.sv ***
/* Checker bound to pvd_image_decode: decode claims, posting and error log.
   Assumes the bench sends no request before the internal reset copy is released. */
`timescale 1ns/1ps
// ==========================================================
// Port checker
module pvd_image_decode_chk
(
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic       DEC_VALID,
  input wire logic       DEC_IO,
  input wire logic       DEC_WRITE,
  input wire logic       DEC_OTHER_HIT,
  input wire logic       DEC_DONE,
  input wire logic       DEC_HIT_SPECIAL,
  input wire logic       DEC_HIT_IMG4,
  input wire logic [1:0] DEC_VME_WIDTH,
  input wire logic       DEC_POSTED,
  input wire logic       DEC_BLT,
  input wire logic       DEC_MBLT,
  input wire logic       ERR_TARGET_ABORT,
  input wire logic       ERR_MASTER_ABORT,
  input wire logic       ERR_RETRY_EXPIRED,
  input wire logic       ERR_POSTED,
  input wire logic       LOG_VALID
);
  logic any_err;
  assign any_err = (ERR_TARGET_ABORT || ERR_MASTER_ABORT || ERR_RETRY_EXPIRED) && ERR_POSTED;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  idle_quiet_a: assert property (!DEC_VALID |=> !DEC_DONE && !DEC_HIT_SPECIAL && !DEC_HIT_IMG4)
    else $error("claim without a decode request");
  other_wins_a: assert property (DEC_VALID && DEC_OTHER_HIT |=> !DEC_HIT_SPECIAL)
    else $error("special image claimed over another image");
  one_image_a: assert property (DEC_DONE |-> !(DEC_HIT_SPECIAL && DEC_HIT_IMG4))
    else $error("two images claimed one access");
  sp_single_a: assert property (DEC_HIT_SPECIAL |-> !DEC_BLT && !DEC_MBLT)
    else $error("block transfer from special image");
  sp_width_a: assert property (DEC_HIT_SPECIAL |-> DEC_VME_WIDTH == 2'h1 || DEC_VME_WIDTH == 2'h2)
    else $error("special image width not 16 or 32");
  io_coupled_a: assert property (DEC_VALID && DEC_IO |=> !DEC_POSTED)
    else $error("io access posted");
  rd_coupled_a: assert property (DEC_VALID && !DEC_WRITE ##1 DEC_DONE |-> !DEC_POSTED)
    else $error("read posted");
  log_set_a: assert property (any_err |=> LOG_VALID)
    else $error("posted write error not logged");
  log_cause_a: assert property (!LOG_VALID && !any_err |=> !LOG_VALID)
    else $error("log valid without an error");
endmodule

bind pvd_image_decode pvd_image_decode_chk chk (.*);

// *** verif/pvd_pci_side.sv ***
/* PCI-side partner: turns bench requests into one-cycle decode and error pulses.
   Assumes each go input is raised for one cycle just after a rising edge. */
`timescale 1ns/1ps
// ==========================================================
// Partner model
module pvd_pci_side
(
  input  wire logic        SYS_CLK,
  input  wire logic        d_go,
  input  wire logic [34:0] d_q,
  input  wire logic        e_go,
  input  wire logic [39:0] e_q,
  output logic             DEC_VALID,
  output logic [34:0]      d_o,
  output logic [39:0]      e_o
);
  initial {DEC_VALID, d_o, e_o} = '0;
  // Idle data lines show the inverse of their last value and error kinds drop to 0, so stale data never looks live
  always @(posedge SYS_CLK)
  begin
    DEC_VALID  <= d_go;
    d_o        <= d_go ? d_q : ~d_o;
    e_o[39:37] <= e_go ? e_q[39:37] : 3'h0;
    e_o[36:0]  <= e_go ? e_q[36:0] : ~e_o[36:0];
  end
endmodule

// *** verif/pvd_image_decode_tb.sv ***
/* Bench for pvd_image_decode: registers, special image, image 4, error log.
   Assumes the partner pvd_pci_side and the bound checker. */
`timescale 1ns/1ps
// ==========================================================
// Bench top
module pvd_image_decode_tb;
  logic        SYS_CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic        S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, DEC_VALID, DEC_IO, DEC_WRITE;
  logic        DEC_OTHER_HIT, DEC_DONE, DEC_HIT_SPECIAL, DEC_HIT_IMG4, DEC_POSTED, DEC_BLT, DEC_MBLT;
  logic        ERR_TARGET_ABORT, ERR_MASTER_ABORT, ERR_RETRY_EXPIRED, ERR_POSTED, LOG_VALID, d_go, e_go;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, DEC_VME_WIDTH;
  logic [2:0]  S_AXI_AWPROT, S_AXI_ARPROT;
  logic [3:0]  S_AXI_WSTRB, ERR_CMD;
  logic [5:0]  DEC_VME_AM;
  logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, DEC_ADDR, DEC_VME_ADDR, ERR_ADDR;
  logic [34:0] d_q;
  logic [39:0] e_q;
  int          fail_count = 0, compares = 0, cyc = 0;
  // Image 4 control words and expected {modifier, block, multiplexed block}
  logic [31:0] c4 [8] = '{32'h8080_0100, 32'h8081_0100, 32'h8082_0100, 32'h8085_0100,
                          32'h8086_0100, 32'h8087_0100, 32'h80c2_0000, 32'h8041_5000};
  logic [7:0]  x4 [8] = '{8'ha4, 8'hee, 8'h2e, 8'hbc, 8'h40, 8'h44, 8'h21, 8'hf8};

  pvd_image_decode uut (.*);
  pvd_pci_side pci (.SYS_CLK(SYS_CLK), .d_go(d_go), .d_q(d_q), .e_go(e_go), .e_q(e_q), .DEC_VALID(DEC_VALID),
                    .d_o({DEC_OTHER_HIT, DEC_WRITE, DEC_IO, DEC_ADDR}),
                    .e_o({ERR_RETRY_EXPIRED, ERR_MASTER_ABORT, ERR_TARGET_ABORT, ERR_POSTED, ERR_CMD, ERR_ADDR}));

  always #4 SYS_CLK = ~SYS_CLK;
  // ==========================================================
  // Shared tasks
  task automatic report_and_stop;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Read when w is 0: d is then the expected data
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hd;
    logic [31:0] rv;
    logic [1:0] rs;
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {3{w}};
    {S_AXI_ARVALID, S_AXI_RREADY} <= {2{!w}};
    hd = 1'b0;
    while (!hd)
    begin
      @(negedge SYS_CLK);
      ha = (S_AXI_AWVALID && S_AXI_AWREADY) || (S_AXI_ARVALID && S_AXI_ARREADY);
      hw = S_AXI_WVALID && S_AXI_WREADY;
      hd = w ? S_AXI_BVALID === 1'b1 : S_AXI_RVALID === 1'b1;
      rs = w ? S_AXI_BRESP : S_AXI_RRESP;
      rv = S_AXI_RDATA;
      @(posedge SYS_CLK);
      if (ha) {S_AXI_AWVALID, S_AXI_ARVALID} <= 2'b00;
      if (hw) S_AXI_WVALID <= 1'b0;
    end
    {S_AXI_BREADY, S_AXI_RREADY} <= 2'b00;
    check(rs, er);
    if (!w) check(rv, d);
  endtask
  // Decode fields: {other hit, write, io, address}; error fields: {kind, posted, command, address}
  task automatic req(input logic isd, input logic [39:0] q);
    @(posedge SYS_CLK);
    d_q <= q[34:0];
    e_q <= q;
    {d_go, e_go} <= {isd, !isd};
    @(posedge SYS_CLK);
    {d_go, e_go} <= 2'b00;
    @(posedge SYS_CLK);
    @(negedge SYS_CLK);
  endtask
  task automatic dchk(input logic [12:0] e);
    check({DEC_DONE, DEC_HIT_SPECIAL, DEC_HIT_IMG4, DEC_POSTED, DEC_BLT, DEC_MBLT, DEC_VME_WIDTH, DEC_VME_AM},
          {1'b1, e});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    bus(0, 12'h018, 32'h0, 2'h0);
    bus(0, 12'h18c, 32'h7000_0000, 2'h0);
    bus(0, 12'h190, 32'h0, 2'h0);
    bus(0, 12'h1a0, 32'h0080_0000, 2'h0);
    bus(0, 12'h1fc, 32'h0, 2'h2);
    bus(1, 12'h1fc, 32'hffff_ffff, 2'h2);
    req(1, 40'h2_0000_1000);
    dchk(13'h0);
  endtask
  task automatic t_special;
    logic [31:0] a;
    logic [1:0] n;
    logic [5:0] am;
    bus(1, 12'h018, 32'hffff_ffff, 2'h0);
    bus(0, 12'h018, 32'hc0f0_fffd, 2'h0);
    bus(1, 12'h018, 32'hc050_2414, 2'h0);
    for (int i = 0; i < 8; i++)
    begin
      n = i[2:1];
      a = {6'h05, n, i[0] ? 8'hff : 8'h12, 16'h3456};
      am = (i[0] ? 6'h29 : 6'h39) + {3'h0, n == 2'h2, 1'b0, n == 2'h1 && !i[0]};
      req(1, {5'h01, 3'b010, a});
      dchk({3'b101, 2'b00, n[0] ? 2'h1 : 2'h2, am});
      check(DEC_VME_ADDR, i[0] ? {16'h0, a[15:0]} : {8'h0, a[23:0]});
    end
    req(1, 40'h2_1800_0000);
    dchk(13'h0);
    req(1, 40'h6_1400_0000);
    check(DEC_HIT_SPECIAL, 1'b0);
    req(1, 40'h3_1400_0000);
    dchk(13'h0);
    req(1, 40'h0_1400_0000);
    dchk({3'b100, 2'b00, 2'h2, 6'h39});
    bus(1, 12'h018, 32'h8050_2414, 2'h0);
    req(1, 40'h2_1400_0000);
    check({DEC_HIT_SPECIAL, DEC_POSTED}, 2'b10);
  endtask
  task automatic t_image4;
    bus(1, 12'h1a0, 32'hffff_ffff, 2'h0);
    bus(0, 12'h1a0, 32'hc0c7_5101, 2'h0);
    bus(1, 12'h1a4, 32'h1500_0abc, 2'h0);
    bus(0, 12'h1a4, 32'h1500_0000, 2'h0);
    bus(1, 12'h1a8, 32'h1500_3000, 2'h0);
    bus(1, 12'h1b0, 32'h1000_0000, 2'h0);
    for (int i = 0; i < 8; i++)
    begin
      bus(1, 12'h1a0, c4[i], 2'h0);
      req(1, 40'h0_1500_2abc);
      dchk({3'b010, x4[i][1:0], c4[i][23:22], x4[i][7:2]});
      if (c4[i][18:16] == 3'h2) check(DEC_VME_ADDR, 32'h2500_2abc);
    end
    bus(1, 12'h1a0, 32'hc082_0000, 2'h0);
    req(1, 40'h2_1500_2abc);
    check({DEC_HIT_IMG4, DEC_POSTED}, 2'b11);
    req(1, 40'h0_1500_3000);
    check({DEC_HIT_SPECIAL, DEC_HIT_IMG4}, 2'b10);
    bus(1, 12'h1a8, 32'h0, 2'h0);
    req(1, 40'h0_7000_0000);
    check(DEC_HIT_IMG4, 1'b1);
    bus(1, 12'h1a0, 32'hc082_0001, 2'h0);
    req(1, 40'h3_7000_0000);
    check({DEC_HIT_IMG4, DEC_POSTED}, 2'b10);
    req(1, 40'h2_7000_0000);
    check(DEC_HIT_IMG4, 1'b0);
    bus(1, 12'h1a0, 32'h4082_0001, 2'h0);
    req(1, 40'h3_7000_0000);
    check(DEC_HIT_IMG4, 1'b0);
  endtask
  task automatic t_log;
    req(0, {3'b010, 1'b0, 4'h3, 32'h0000_0100});
    check(LOG_VALID, 1'b0);
    req(0, {3'b001, 1'b1, 4'h3, 32'hdead_0000});
    check(LOG_VALID, 1'b1);
    bus(0, 12'h18c, 32'h3080_0000, 2'h0);
    req(0, {3'b100, 1'b1, 4'hb, 32'h0bad_0000});
    bus(0, 12'h18c, 32'h3880_0000, 2'h0);
    bus(1, 12'h190, 32'hffff_ffff, 2'h0);
    bus(0, 12'h190, 32'hdead_0000, 2'h0);
    bus(1, 12'h18c, 32'h0, 2'h0);
    check(LOG_VALID, 1'b1);
    bus(1, 12'h18c, 32'h0080_0000, 2'h0);
    check(LOG_VALID, 1'b0);
    req(0, {3'b010, 1'b1, 4'h5, 32'h0000_1230});
    bus(0, 12'h18c, 32'h5080_0000, 2'h0);
    bus(0, 12'h190, 32'h0000_1230, 2'h0);
  endtask
  // ==========================================================
  // Run control
  always @(posedge SYS_CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      report_and_stop;
    end
  end
  initial
  begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, d_go, e_go} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_AWPROT, S_AXI_ARPROT, S_AXI_WDATA, d_q, e_q} = '0;
    S_AXI_WSTRB = 4'hf;
    repeat (6) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    t_reset;
    t_special;
    t_image4;
    t_log;
    report_and_stop;
  end
endmodule
